// *** design/miu_interrupt_unit.sv ***
// Interrupt unit: one non-maskable and four maskable sources, config
// registers on classic Wishbone, entry/return handshake with the core.
// Assumes the core pulses instr_done after each instruction and follows
// irq_entry by pushing its PC and jumping to vector_addr.
//
// Operation
// - One non-maskable source plus four maskable sources, each with own vector.
// - Accepted request loads PC with its vector entry address.
// - Several events OR into one source; per-event flags stay readable.
// - NMI preempts normal code and maskable routines; maskable never preempts maskable.
// - Pending maskable requests served in fixed order, source 1 first.
// - Vectors NMI FFCh, src1 FF6h, src2 FF4h, src3 FF2h, src4 FF0h.
// - Global enable bit 4 gates maskable sources; NMI entry never gated.
// - With global enable clear no source wakes the core.
// - NMI captured in a flip-flop, cleared as its routine begins.
// - Source 1 level (low) when bit 6 set, else falling edge.
// - Source 2 edge; rising when bit 5 set, else falling.
// - Sources 3 and 4 are level only.
// - Edge latch set on edge, cleared on entry; extra edges collapse.
// - Level requests not stored; sampled after each instruction.
// - Lines tested after every instruction; request replaces next one.
// - Entry switches flags, pushes PC, inhibits maskable, clears latch, vectors.
// - Separate flag sets for normal, interrupt and NMI modes.
// - Return restores previous flag set and pops PC.
// - Request in first 3 cycles of zero config write keeps normal flags; an NMI entry there still selects the NMI flags.
// - Config at C8h write-only, whole byte only, reset 00h, bits 7,3-0 unused.
// - Timer/converter to vector 4, reload timer to 3, ports A/B 1, C 2.
// - Each event needs its own mask bit besides the global enable.
// - Wait/stop not entered while an enabled request is pending.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
module miu_interrupt_unit
   import miu_pkg::*;
#(
   parameter int PORT_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Pins (asynchronous)
   input  wire logic              nmi_pin_n,
   input  wire logic [PORT_W-1:0] port_a_pins,
   input  wire logic [PORT_W-1:0] port_b_pins,
   input  wire logic [PORT_W-1:0] port_c_pins,
   // Peripheral event flags (same clock)
   input  wire logic              timer_overflow_flag,
   input  wire logic              converter_done_flag,
   input  wire logic              reload_timer_overflow_flag,
   input  wire logic              reload_timer_compare_flag,
   input  wire logic              reload_timer_edge_flag,
   // Core sequencer
   input  wire logic              instr_done,
   input  wire logic              return_from_irq_instr,
   input  wire logic              sleep_instr,
   output logic                   irq_entry,
   output logic      [11:0]       vector_addr,
   output miu_mode_type           core_mode,
   output miu_mode_type           flag_bank,
   output logic                   low_power,
   output logic                   wake_up
);

   // ----------------------------------------------------------------
   // Registers and pin synchronisers
   // ----------------------------------------------------------------
   logic [7:0]        interrupt_config;
   logic [4:0]        periph_mask;
   logic [23:0]       port_enable;
   logic [1:0]        acc_cnt;
   logic [2:0]        nmi_sync;
   logic [PORT_W-1:0] pa_meta, pa_sync, pb_meta, pb_sync, pc_meta, pc_sync;
   logic              src1_prev, src2_prev;
   logic              nmi_latch, src1_latch, src2_latch;
   miu_mode_type      nmi_ret_mode, nmi_ret_bank;
   logic              wr_hit;

   logic global_irq_enable, src1_level_select, src2_edge_polarity;
   assign global_irq_enable  = interrupt_config[CFG_GLOBAL_IRQ_ENABLE];
   assign src1_level_select  = interrupt_config[CFG_SRC1_LEVEL_SELECT];
   assign src2_edge_polarity = interrupt_config[CFG_SRC2_EDGE_POLARITY];

   // Any enabled pin of the group held low
   function automatic logic any_low(input logic [PORT_W-1:0] pins,
                                    input logic [PORT_W-1:0] en);
      any_low = |(~pins & en);
   endfunction : any_low

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle pin level, so no pin looks low right after reset
         pa_meta  <= '1;
         pa_sync  <= '1;
         pb_meta  <= '1;
         pb_sync  <= '1;
         pc_meta  <= '1;
         pc_sync  <= '1;
         nmi_sync <= 3'h7;
      end else begin
         pa_meta  <= port_a_pins;
         pa_sync  <= pa_meta;
         pb_meta  <= port_b_pins;
         pb_sync  <= pb_meta;
         pc_meta  <= port_c_pins;
         pc_sync  <= pc_meta;
         nmi_sync <= {nmi_sync[1:0], nmi_pin_n};
      end
   end

   // ----------------------------------------------------------------
   // Source lines
   // ----------------------------------------------------------------
   logic src1_active, src2_line, src3_req, src4_req;
   logic src1_fall, src2_edge, nmi_fall;
   logic [4:1] req;

   // Ports A and B share source 1, port C alone drives source 2
   assign src1_active = any_low(pa_sync, port_enable[PE_PORT_A_LSB +: PORT_W])
                      | any_low(pb_sync, port_enable[PE_PORT_B_LSB +: PORT_W]);
   assign src2_line   = ~any_low(pc_sync, port_enable[PE_PORT_C_LSB +: PORT_W]);
   assign src3_req = (reload_timer_overflow_flag & periph_mask[PM_RT_OVF])
                   | (reload_timer_compare_flag  & periph_mask[PM_RT_CMP])
                   | (reload_timer_edge_flag     & periph_mask[PM_RT_EDGE]);
   assign src4_req = (timer_overflow_flag & periph_mask[PM_TIMER])
                   | (converter_done_flag & periph_mask[PM_CONVERTER]);

   assign src1_fall = src1_active & ~src1_prev;
   assign src2_edge = src2_edge_polarity ? (src2_line & ~src2_prev)
                                         : (~src2_line & src2_prev);
   assign nmi_fall  = ~nmi_sync[1] & nmi_sync[2];

   // Level sources are looked at only now, never stored
   assign req[1] = src1_level_select ? src1_active : src1_latch;
   assign req[2] = src2_latch;
   assign req[3] = src3_req;
   assign req[4] = src4_req;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         src1_prev <= 1'b0;
         src2_prev <= 1'b1;
      end else begin
         src1_prev <= src1_active;
         src2_prev <= src2_line;
      end
   end

   // ----------------------------------------------------------------
   // Entry decision
   // ----------------------------------------------------------------
   logic       take_nmi, take_mask, take_any, anomaly_win;
   logic [4:1] grant;
   logic [11:0] next_vector;

   assign take_nmi  = nmi_latch & (core_mode != MODE_NMI);
   assign take_mask = (core_mode == MODE_NORMAL) & global_irq_enable & (|req);
   assign take_any  = take_nmi | take_mask;

   // Config write of zero still in its first three cycles
   assign anomaly_win = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
                      & (wb_adr_i == ADR_INTERRUPT_CONFIG)
                      & (wb_dat_i[7:0] == CONFIG_ZERO);

   always_comb begin
      grant       = 4'h0;
      next_vector = VEC_NMI;
      if (take_nmi) begin
         next_vector = VEC_NMI;
      end else if (req[1]) begin
         grant[1]    = 1'b1;
         next_vector = VEC_SRC1;
      end else if (req[2]) begin
         grant[2]    = 1'b1;
         next_vector = VEC_SRC2;
      end else if (req[3]) begin
         grant[3]    = 1'b1;
         next_vector = VEC_SRC3;
      end else if (req[4]) begin
         grant[4]    = 1'b1;
         next_vector = VEC_SRC4;
      end
   end

   logic entering;
   assign entering = instr_done & take_any;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_entry   <= 1'b0;
         vector_addr <= VEC_NMI;
      end else begin
         irq_entry <= entering;
         if (entering) begin
            vector_addr <= next_vector;
         end
      end
   end

   // ----------------------------------------------------------------
   // Request latches; a new edge beats the clear of the same cycle
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nmi_latch  <= 1'b0;
         src1_latch <= 1'b0;
         src2_latch <= 1'b0;
      end else begin
         if (nmi_fall) begin
            nmi_latch <= 1'b1;
         end else if (entering && take_nmi) begin
            nmi_latch <= 1'b0;
         end
         if (src1_fall && !src1_level_select) begin
            src1_latch <= 1'b1;
         end else if (entering && !take_nmi && grant[1]) begin
            src1_latch <= 1'b0;
         end
         if (src2_edge) begin
            src2_latch <= 1'b1;
         end else if (entering && !take_nmi && grant[2]) begin
            src2_latch <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode and flag bank
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core_mode    <= MODE_NORMAL;
         flag_bank    <= MODE_NORMAL;
         nmi_ret_mode <= MODE_NORMAL;
         nmi_ret_bank <= MODE_NORMAL;
      end else if (entering && take_nmi) begin
         nmi_ret_mode <= core_mode;
         nmi_ret_bank <= flag_bank;
         core_mode    <= MODE_NMI;
         flag_bank    <= MODE_NMI;
      end else if (entering) begin
         core_mode <= MODE_IRQ;
         // Known quirk: zero write to config races the bank switch
         if (!anomaly_win) begin
            flag_bank <= MODE_IRQ;
         end
      end else if (return_from_irq_instr) begin
         if (core_mode == MODE_NMI) begin
            core_mode <= nmi_ret_mode;
            flag_bank <= nmi_ret_bank;
         end else begin
            core_mode <= MODE_NORMAL;
            flag_bank <= MODE_NORMAL;
         end
      end
   end

   // ----------------------------------------------------------------
   // Wait / stop
   // ----------------------------------------------------------------
   logic pending, wake_req;
   assign pending  = nmi_latch | (global_irq_enable & (|req));
   assign wake_req = global_irq_enable & (nmi_latch | (|req));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         low_power <= 1'b0;
         wake_up   <= 1'b0;
      end else begin
         wake_up <= low_power & wake_req;
         if (low_power && wake_req) begin
            low_power <= 1'b0;
         end else if (sleep_instr && !pending) begin
            low_power <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Wishbone slave; every access answers after ACK_WAIT+1 wait states
   // ----------------------------------------------------------------
   logic bus_req;
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_hit  = bus_req & wb_we_i & wb_ack_o;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_cnt  <= 2'h0;
         wb_ack_o <= 1'b0;
      end else if (wb_ack_o || !bus_req) begin
         acc_cnt  <= 2'h0;
         wb_ack_o <= 1'b0;
      end else if (acc_cnt == ACK_WAIT) begin
         wb_ack_o <= 1'b1;
      end else begin
         acc_cnt <= acc_cnt + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         interrupt_config <= CONFIG_RESET;
         periph_mask      <= PERIPH_MASK_RESET;
         port_enable      <= PORT_ENABLE_RESET;
      end else if (wr_hit) begin
         // Whole-byte writes only; unused bits never stored
         if (wb_adr_i == ADR_INTERRUPT_CONFIG && wb_sel_i[0]) begin
            interrupt_config <= wb_dat_i[7:0] & 8'h70;
         end else if (wb_adr_i == ADR_PERIPH_MASK && wb_sel_i[0]) begin
            periph_mask <= wb_dat_i[4:0];
         end else if (wb_adr_i == ADR_PORT_ENABLE) begin
            for (int i = 0; i < 3; i++) begin
               if (wb_sel_i[i]) begin
                  port_enable[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
               end
            end
         end
      end
   end

   logic [7:0] event_flags, unit_status;
   assign event_flags = {any_low(pc_sync, {PORT_W{1'b1}}),
                         any_low(pb_sync, {PORT_W{1'b1}}),
                         any_low(pa_sync, {PORT_W{1'b1}}),
                         reload_timer_edge_flag, reload_timer_compare_flag,
                         reload_timer_overflow_flag, converter_done_flag,
                         timer_overflow_flag};
   assign unit_status = {low_power, src2_latch, src1_latch, nmi_latch,
                         flag_bank, core_mode};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (bus_req && !wb_we_i && acc_cnt == ACK_WAIT && !wb_ack_o) begin
         // Config is write-only and reads back zero
         if (wb_adr_i == ADR_PERIPH_MASK) begin
            wb_dat_o <= {27'h0, periph_mask};
         end else if (wb_adr_i == ADR_EVENT_FLAGS) begin
            wb_dat_o <= {24'h000000, event_flags};
         end else if (wb_adr_i == ADR_PORT_ENABLE) begin
            wb_dat_o <= {8'h00, port_enable};
         end else if (wb_adr_i == ADR_UNIT_STATUS) begin
            wb_dat_o <= {24'h000000, unit_status};
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_nmi_taken;
      @(posedge mclk) disable iff (!reset_n)
      instr_done && nmi_latch && core_mode != MODE_NMI
         |=> irq_entry && vector_addr == VEC_NMI && core_mode == MODE_NMI;
   endproperty
   a_nmi_taken: assert property (p_nmi_taken)
      else $error("NMI not taken with its vector");

   property p_no_mask_nest;
      @(posedge mclk) disable iff (!reset_n)
      instr_done && core_mode == MODE_IRQ && !nmi_latch |=> !irq_entry;
   endproperty
   a_no_mask_nest: assert property (p_no_mask_nest)
      else $error("maskable request nested in maskable routine");

   property p_global_block;
      @(posedge mclk) disable iff (!reset_n)
      instr_done && !global_irq_enable && !nmi_latch |=> !irq_entry;
   endproperty
   a_global_block: assert property (p_global_block)
      else $error("maskable entry with global enable clear");

   property p_prio_src1;
      @(posedge mclk) disable iff (!reset_n)
      instr_done && core_mode == MODE_NORMAL && global_irq_enable && !nmi_latch && req[1]
         |=> irq_entry && vector_addr == VEC_SRC1;
   endproperty
   a_prio_src1: assert property (p_prio_src1)
      else $error("source 1 not first");

   property p_nmi_clear;
      @(posedge mclk) disable iff (!reset_n)
      instr_done && take_nmi && !nmi_fall |=> !nmi_latch;
   endproperty
   a_nmi_clear: assert property (p_nmi_clear)
      else $error("NMI latch not cleared on entry");

   property p_no_wake;
      @(posedge mclk) disable iff (!reset_n)
      !global_irq_enable |=> !wake_up;
   endproperty
   a_no_wake: assert property (p_no_wake)
      else $error("wake-up with global enable clear");

   property p_sleep_refused;
      @(posedge mclk) disable iff (!reset_n)
      sleep_instr && !low_power && pending |=> !low_power;
   endproperty
   a_sleep_refused: assert property (p_sleep_refused)
      else $error("low power entered with request pending");

   property p_return;
      @(posedge mclk) disable iff (!reset_n)
      return_from_irq_instr && !entering && core_mode == MODE_IRQ
         |=> core_mode == MODE_NORMAL && flag_bank == MODE_NORMAL;
   endproperty
   a_return: assert property (p_return)
      else $error("return did not restore normal flags");

   property p_entry_pulse;
      @(posedge mclk) disable iff (!reset_n)
      irq_entry |=> !irq_entry;
   endproperty
   a_entry_pulse: assert property (p_entry_pulse)
      else $error("entry pulse longer than one cycle");

   property p_bank_switch;
      @(posedge mclk) disable iff (!reset_n)
      entering && !take_nmi && !anomaly_win |=> flag_bank == MODE_IRQ;
   endproperty
   a_bank_switch: assert property (p_bank_switch)
      else $error("interrupt flag bank not selected");

endmodule : miu_interrupt_unit

// *** design/miu_pkg.sv ***
// Constants and types for the interrupt unit of the 8-bit core.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package miu_pkg;
   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0]  ADR_INTERRUPT_CONFIG = 8'hC8;
   localparam logic [7:0]  ADR_PERIPH_MASK      = 8'hCC;
   localparam logic [7:0]  ADR_EVENT_FLAGS      = 8'hD0;
   localparam logic [7:0]  ADR_PORT_ENABLE      = 8'hD4;
   localparam logic [7:0]  ADR_UNIT_STATUS      = 8'hD8;

   localparam logic [7:0]  CONFIG_RESET         = 8'h00;
   localparam logic [7:0]  CONFIG_ZERO          = 8'h00;
   localparam logic [4:0]  PERIPH_MASK_RESET    = 5'h00;
   localparam logic [23:0] PORT_ENABLE_RESET    = 24'h000000;

   // Field positions in interrupt_config
   localparam int CFG_SRC1_LEVEL_SELECT  = 6;
   localparam int CFG_SRC2_EDGE_POLARITY = 5;
   localparam int CFG_GLOBAL_IRQ_ENABLE  = 4;

   // Field positions in the peripheral mask register
   localparam int PM_TIMER     = 0;
   localparam int PM_CONVERTER = 1;
   localparam int PM_RT_OVF    = 2;
   localparam int PM_RT_CMP    = 3;
   localparam int PM_RT_EDGE   = 4;

   // Port enable byte lanes
   localparam int PE_PORT_A_LSB = 0;
   localparam int PE_PORT_B_LSB = 8;
   localparam int PE_PORT_C_LSB = 16;

   // -----------------------------------------------------------------
   // Vectors in program space
   // -----------------------------------------------------------------
   localparam logic [11:0] VEC_NMI  = 12'hFFC;
   localparam logic [11:0] VEC_SRC1 = 12'hFF6;
   localparam logic [11:0] VEC_SRC2 = 12'hFF4;
   localparam logic [11:0] VEC_SRC3 = 12'hFF2;
   localparam logic [11:0] VEC_SRC4 = 12'hFF0;

   // Bus answer: ack rises after one more wait state than this value
   localparam logic [1:0]  ACK_WAIT = 2'h2;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_IRQ,
      MODE_NMI
   } miu_mode_type;
endpackage : miu_pkg

// *** bench/miu_core_model.sv ***
// Core sequencer model: retires one instruction every four cycles.
// Assumes the unit answers an entry with a one-cycle irq_entry pulse.
`timescale 1ns/10ps
module miu_core_model (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic low_power,
   input  wire logic irq_entry,
   output logic      instr_done
);
   logic [1:0] phase;
   // -----------------------------------------------------------------
   // Instruction pacing
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phase      <= 2'h0;
         instr_done <= 1'b0;
      end else begin
         phase      <= phase + 2'h1;
         // Halted core retires nothing; irq_entry is high only at phase 1, so an entry drops no retire
         instr_done <= (phase == 2'h3) && !low_power && !irq_entry;
      end
   end
endmodule : miu_core_model

// *** bench/miu_interrupt_unit_bench.sv ***
// Bench for the interrupt unit: random and corner requests, bus, sleep.
// Assumes the core model paces instructions and the bus always answers.
`timescale 1ns/10ps
module miu_interrupt_unit_bench;
   import miu_pkg::*;
   logic         mclk = 1'b0, reset_n = 1'b0;
   logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, ret = 1'b0, slp = 1'b0;
   logic         nmi_n = 1'b1;
   logic [7:0]   adr = 8'h00, pa = 8'hFF, pb = 8'hFF, pc = 8'hFF;
   logic [3:0]   sel = 4'h0;
   logic [31:0]  dwr = 32'h0, drd, q;
   logic [4:0]   fl = 5'h00;
   logic         ack, done, ent, lp, wk;
   logic [11:0]  vec;
   miu_mode_type mode, bank;
   int           mismatches = 0, samples_checked = 0;

   miu_interrupt_unit #(.PORT_W(8)) uut (.mclk(mclk), .reset_n(reset_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .nmi_pin_n(nmi_n),
      .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
      .timer_overflow_flag(fl[0]), .converter_done_flag(fl[1]),
      .reload_timer_overflow_flag(fl[2]), .reload_timer_compare_flag(fl[3]),
      .reload_timer_edge_flag(fl[4]), .instr_done(done), .return_from_irq_instr(ret),
      .sleep_instr(slp), .irq_entry(ent), .vector_addr(vec), .core_mode(mode),
      .flag_bank(bank), .low_power(lp), .wake_up(wk));
   miu_core_model core (.mclk(mclk), .reset_n(reset_n), .low_power(lp),
      .irq_entry(ent), .instr_done(done));

   always #4 mclk = ~mclk;

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dwr <= d;
      sel <= 4'hF;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = drd;
      chk("bus ack", 32'h1, 32'(ack));
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic take(input logic [11:0] v, input miu_mode_type m);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ent !== 1'b1 && n < 40);
      chk("entry", 32'h1, 32'(ent));
      chk("vector", 32'(v), 32'(vec));
      chk("mode", 32'(m), 32'(mode));
      chk("bank", 32'(m), 32'(bank));
   endtask : take

   task automatic quiet;
      int c;
      c = 0;
      repeat (24) begin
         @(posedge mclk);
         c += int'(ent === 1'b1);
      end
      chk("no entry", 32'h0, 32'(c));
   endtask : quiet

   task automatic leave;
      @(posedge mclk);
      ret <= 1'b1;
      @(posedge mclk);
      ret <= 1'b0;
   endtask : leave

   task automatic nap;
      @(posedge mclk);
      slp <= 1'b1;
      @(posedge mclk);
      slp <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : nap

   // Source 3 outranks source 4; each event needs its own mask bit
   function automatic logic [11:0] exp_vec(input logic [4:0] f, input logic [4:0] m);
      if (|(f[4:2] & m[4:2])) return VEC_SRC3;
      if (|(f[1:0] & m[1:0])) return VEC_SRC4;
      return 12'h000;
   endfunction : exp_vec

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      logic [4:0]  f, m;
      logic [11:0] e;
      int          n;
      void'($urandom(32));
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("vector", 32'(VEC_NMI), 32'(vec));
      chk("mode", 32'(MODE_NORMAL), 32'(mode));
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h70);
      wb(1'b0, ADR_INTERRUPT_CONFIG, 32'h0);
      chk("config read", 32'h0, q);
      wb(1'b0, 8'hE0, 32'h0);
      chk("unmapped read", 32'h0, q);
      $display("test registers done");
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h10);
      for (int i = 0; i < 12; i++) begin
         f = (i == 0) ? 5'h1F : (i == 1) ? 5'h02 : 5'($urandom);
         m = (i == 0) ? 5'h1F : (i == 1) ? 5'h01 : 5'($urandom);
         wb(1'b1, ADR_PERIPH_MASK, 32'(m));
         wb(1'b0, ADR_PERIPH_MASK, 32'h0);
         chk("periph mask", 32'(m), q);
         fl <= f;
         e = exp_vec(f, m);
         if (e !== 12'h000) begin
            take(e, MODE_IRQ);
            quiet();
         end else quiet();
         wb(1'b0, ADR_EVENT_FLAGS, 32'h0);
         chk("event flags", 32'(f), q);
         fl <= 5'h00;
         if (e !== 12'h000) begin
            leave();
            @(posedge mclk);
            chk("mode", 32'(MODE_NORMAL), 32'(mode));
         end
      end
      $display("test random sources done");
      wb(1'b1, ADR_PERIPH_MASK, 32'h1F);
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h00);
      fl <= 5'h1F;
      quiet();
      nmi_n <= 1'b0;
      take(VEC_NMI, MODE_NMI);
      wb(1'b0, ADR_UNIT_STATUS, 32'h0);
      chk("status", 32'({4'h0, MODE_NMI, MODE_NMI}), q);
      nmi_n <= 1'b1;
      fl <= 5'h00;
      leave();
      quiet();
      $display("test nmi done");
      wb(1'b1, ADR_PORT_ENABLE, 32'h010101);
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h10);
      fl <= 5'h01;
      take(VEC_SRC4, MODE_IRQ);
      repeat (2) begin
         @(posedge mclk);
         pc <= 8'hFE;
         repeat (4) @(posedge mclk);
         pc <= 8'hFF;
      end
      nap();
      chk("low power", 32'h0, 32'(lp));
      fl <= 5'h00;
      repeat (4) @(posedge mclk);
      leave();
      take(VEC_SRC2, MODE_IRQ);
      leave();
      quiet();
      pb <= 8'hFE;
      take(VEC_SRC1, MODE_IRQ);
      pb <= 8'hFF;
      leave();
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h50);
      pa <= 8'hFE;
      take(VEC_SRC1, MODE_IRQ);
      pa <= 8'hFF;
      repeat (4) @(posedge mclk);
      leave();
      quiet();
      $display("test pins done");
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h00);
      nap();
      chk("low power", 32'h1, 32'(lp));
      nmi_n <= 1'b0;
      n = 0;
      repeat (24) begin
         @(posedge mclk);
         n += int'(wk === 1'b1);
      end
      chk("wake count", 32'h0, 32'(n));
      chk("low power", 32'h1, 32'(lp));
      nmi_n <= 1'b1;
      reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("low power", 32'h0, 32'(lp));
      quiet();
      wb(1'b1, ADR_PERIPH_MASK, 32'h01);
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h10);
      nap();
      fl <= 5'h01;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wk !== 1'b1 && n < 20);
      chk("wake", 32'h1, 32'(wk));
      take(VEC_SRC4, MODE_IRQ);
      fl <= 5'h00;
      leave();
      // Align so the next instruction end falls inside the zero config write
      do @(posedge mclk); while (done !== 1'b1);
      fl <= 5'h01;
      wb(1'b1, ADR_INTERRUPT_CONFIG, 32'h00);
      chk("mode", 32'(MODE_IRQ), 32'(mode));
      chk("bank", 32'(MODE_NORMAL), 32'(bank));
      fl <= 5'h00;
      leave();
      $display("test sleep done");
      end_of_test();
   end

   // Whole run is about a thousand cycles; the 20000-cycle limit is ample margin
   initial begin
      #160000;
      mismatches++;
      end_of_test();
   end
endmodule : miu_interrupt_unit_bench
